// ### hdl/tfs_seq.sv
// tfs_seq: trigger flow sequencer top with APB register file
// assumes probed inputs synchronous to clk_sys; buffer memory lives outside
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module tfs_seq
  import tfs_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  input  wire logic [15:0]    paddr,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [31:0]    pwdata,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire logic [NIN-1:0] trig_in,
  input  wire logic           ext_trig_in,
  output logic                buf_wr_en,
  output logic [SW-1:0]       buf_seg,
  output logic                buf_seg_adv,
  output logic                buf_seg_cut,
  output logic [CW-1:0]       buf_inv_cnt,
  output logic                buf_done
);
  logic rst_m, rst_s_n;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_m   <= 1'b0;
      rst_s_n <= 1'b0;
    end else begin
      rst_m   <= 1'b1;
      rst_s_n <= rst_m;
    end
  end

  function automatic logic [7:0] tix(input logic [5:0] c, input logic [1:0] w);
    tix = 8'(c) * 8'h03 + 8'(w);
  endfunction

  logic [31:0]   term_mem [NCLT*3];
  logic [31:0]   act_mem [NCLT];
  logic [31:0]   aux_mem [NCLT];
  logic          arm, qual_st, ext_en;
  logic [CW-1:0] dpf;
  logic [SW-1:0] nseg;
  logic [NFLG-1:0] flg_init, flg;
  logic [CW-1:0] cnt_init [NCNT];
  logic [4:0]    cnt_w [NCNT];
  logic [CW-1:0] cnt [NCNT];
  logic [SW-1:0] cur_st;
  logic          ext_seen, run, seg_err;

  // register access
  logic       acc, wr, in_cls, in_cnti, in_cntv, addr_err;
  logic [5:0] cix;
  logic [2:0] cw;
  logic [4:0] rix;
  logic [31:0] rd_val;
  logic        rd_hit;
  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign in_cls  = paddr >= A_CLS && paddr < A_CLS_END;
  assign cix     = 6'((paddr - A_CLS) >> 5);
  assign cw      = paddr[4:2];
  assign rix     = paddr[6:2];
  assign in_cnti = paddr[15:7] == A_CNTI[15:7] && rix < 5'(NCNT);
  assign in_cntv = paddr[15:7] == A_CNTV[15:7] && rix < 5'(NCNT);
  // zero wait: data is registered in the setup cycle, so access always completes
  assign pready  = acc;
  assign pslverr = acc && addr_err;

  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (in_cls) begin
      case (cw)
        3'h0, 3'h1, 3'h2: rd_val = term_mem[tix(cix, cw[1:0])];
        3'h3: rd_val = act_mem[cix];
        3'h4: rd_val = aux_mem[cix];
        default: rd_hit = 1'b0;
      endcase
    end else if (in_cnti) begin
      rd_val = {11'h000, cnt_w[rix], cnt_init[rix]};
    end else if (in_cntv) begin
      rd_val = 32'(cnt[rix]);
    end else begin
      case (paddr)
        A_CTRL: rd_val = 32'({ext_en, qual_st, 1'b0});
        A_STAT: begin
          rd_val[S_RUN]      = run;
          rd_val[S_DON]      = buf_done;
          rd_val[S_ERR]      = seg_err;
          rd_val[S_WE]       = buf_wr_en;
          rd_val[S_ST+:SW]   = cur_st;
          rd_val[S_SEG+:SW]  = buf_seg;
        end
        A_DPF:  rd_val = 32'(dpf);
        A_NSEG: rd_val = 32'(nseg);
        A_FLGI: rd_val = 32'(flg_init);
        A_FLGV: rd_val = 32'(flg);
        A_INV:  rd_val = 32'(buf_inv_cnt);
        default: rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      prdata   <= '0;
      addr_err <= 1'b0;
    end else if (psel && !penable) begin
      prdata   <= pwrite ? '0 : rd_val;
      addr_err <= !rd_hit;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      for (int i = 0; i < NCLT*3; i++) term_mem[i] <= '0;
      for (int i = 0; i < NCLT; i++) begin
        act_mem[i] <= '0;
        aux_mem[i] <= '0;
      end
    end else if (wr && in_cls) begin
      case (cw)
        3'h0, 3'h1, 3'h2: term_mem[tix(cix, cw[1:0])] <= pwdata;
        3'h3: act_mem[cix] <= pwdata;
        3'h4: aux_mem[cix] <= pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      arm      <= 1'b0;
      qual_st  <= 1'b0;
      ext_en   <= 1'b0;
      dpf      <= '0;
      nseg     <= '0;
      flg_init <= '0;
    end else begin
      arm <= wr && paddr == A_CTRL && pwdata[C_ARM];
      if (wr && paddr == A_CTRL) begin
        qual_st <= pwdata[C_QS];
        ext_en  <= pwdata[C_EXT];
      end
      if (wr && paddr == A_DPF) dpf <= pwdata[CW-1:0];
      if (wr && paddr == A_NSEG) nseg <= pwdata[SW-1:0];
      if (wr && paddr == A_FLGI) flg_init <= pwdata[NFLG-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      for (int k = 0; k < NCNT; k++) begin
        cnt_init[k] <= '0;
        cnt_w[k]    <= '0;
      end
    end else if (wr && in_cnti) begin
      cnt_init[rix] <= pwdata[CW-1:0];
      cnt_w[rix]    <= pwdata[I_W+:5];
    end
  end

  // clause evaluation for the current state
  logic [5:0]   base;
  logic [31:0]  tsel [NCL][3];
  logic [NCL-1:0] hits;
  logic [1:0]   sel;
  logic [5:0]   csel;
  logic [31:0]  act, aux;
  logic         eval_ok, take;
  assign base = 6'(cur_st) * 6'(NCL);
  always_comb begin
    for (int j = 0; j < NCL; j++) begin
      for (int w = 0; w < 3; w++) tsel[j][w] = term_mem[tix(6'(base + 6'(j)), 2'(w))];
    end
  end
  for (genvar j = 0; j < NCL; j++) begin : g_cl
    tfs_cond u_cond (
      .term    (tsel[j]),
      .lut     (act_mem[base + 6'(j)][A_LUT+:8]),
      .trig_in (trig_in),
      .cnt     (cnt),
      .flg     (flg),
      .hit     (hits[j])
    );
  end
  always_comb begin
    sel = '0;
    for (int j = NCL - 1; j >= 0; j--) begin
      if (hits[j]) sel = 2'(j);
    end
  end
  assign csel    = base + 6'(sel);
  assign act     = act_mem[csel];
  assign aux     = aux_mem[csel];
  // external trigger is checked first; the sequencer waits until it has fired
  assign eval_ok = run && (!ext_en || ext_seen);
  assign take    = eval_ok && |hits;

  logic [1:0]    cop, fop;
  logic [4:0]    cidx, fidx;
  logic [SW-1:0] gtgt;
  assign cop  = act[A_COP+:2];
  assign fop  = act[A_FOP+:2];
  assign cidx = act[A_CIX+:5];
  assign fidx = act[A_FIX+:5];
  assign gtgt = aux[X_GT+:SW];

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ext_seen <= 1'b0;
    end else if (arm) begin
      ext_seen <= 1'b0;
    end else if (run && ext_en && ext_trig_in) begin
      ext_seen <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      cur_st <= '0;
    end else if (arm) begin
      cur_st <= '0;
    end else if (take && act[A_GEN] && gtgt < 5'(NST)) begin
      cur_st <= gtgt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      for (int k = 0; k < NCNT; k++) cnt[k] <= '0;
    end else begin
      for (int k = 0; k < NCNT; k++) begin
        if (arm) begin
          cnt[k] <= cnt_init[k] & cmask(cnt_w[k]);
        end else if (take && cidx == 5'(k)) begin
          case (cop)
            C_INC: cnt[k] <= (cnt[k] + 16'h0001) & cmask(cnt_w[k]);
            C_DEC: cnt[k] <= (cnt[k] - 16'h0001) & cmask(cnt_w[k]);
            C_RST: cnt[k] <= cnt_init[k] & cmask(cnt_w[k]);
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      flg <= '0;
    end else if (arm) begin
      flg <= flg_init;
    end else if (take && fidx < 5'(NFLG)) begin
      if (fop == F_SET) flg[fidx] <= 1'b1;
      else if (fop == F_CLR) flg[fidx] <= 1'b0;
    end
  end

  tfs_buf u_buf (
    .clk_sys (clk_sys),
    .rst_n   (rst_s_n),
    .arm     (arm),
    .qual_st (qual_st),
    .nseg    (nseg),
    .dpf     (dpf),
    .take    (take),
    .top     (act[A_TOP+:2]),
    .sop     (act[A_SOP+:2]),
    .pf_en   (act[A_PEN]),
    .pf      (aux[X_PF+:CW]),
    .run     (run),
    .wr_en   (buf_wr_en),
    .seg     (buf_seg),
    .seg_adv (buf_seg_adv),
    .seg_cut (buf_seg_cut),
    .inv_cnt (buf_inv_cnt),
    .done    (buf_done),
    .seg_err (seg_err)
  );

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_s_n);
  property p_hold;
    eval_ok && hits == '0 && !arm |=> $stable(cur_st) && $stable(flg) && $stable(cnt[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("state or resource moved without a true clause");
  property p_prio;
    take |-> (hits & ((3'h1 << sel) - 3'h1)) == '0 && hits[sel];
  endproperty
  a_prio: assert property (p_prio) else $error("lower priority clause selected");
  property p_goto;
    take && !arm && act[A_GEN] && gtgt < 5'(NST) |=> cur_st == $past(gtgt);
  endproperty
  a_goto: assert property (p_goto) else $error("goto target not reached");
  property p_inc;
    take && !arm && cop == C_INC && cidx == 5'h00 |=> cnt[0] == (($past(cnt[0]) + 16'h0001) & cmask(cnt_w[0]));
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_dec;
    take && !arm && cop == C_DEC && cidx == 5'h00 |=> cnt[0] == (($past(cnt[0]) - 16'h0001) & cmask(cnt_w[0]));
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");
  property p_rst;
    take && !arm && cop == C_RST && cidx == 5'h00 |=> cnt[0] == (cnt_init[0] & cmask(cnt_w[0]));
  endproperty
  a_rst: assert property (p_rst) else $error("counter reset wrong");
  property p_set;
    take && !arm && fop == F_SET && fidx < 5'(NFLG) |=> flg[$past(fidx)];
  endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_clr;
    take && !arm && fop == F_CLR && fidx < 5'(NFLG) |=> !flg[$past(fidx)];
  endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_ext;
    run && ext_en && !ext_seen |-> !take;
  endproperty
  a_ext: assert property (p_ext) else $error("clause acted before external trigger");
endmodule
`default_nettype wire

// ### pkg/tfs_pkg.sv
// tfs_pkg: constants, field layout and types of the trigger flow sequencer
// assumes one sample clock and an APB slave port with 32-bit data
// Behaviour
// - clauses of a state are checked in order; only the first true one acts
// - all actions of the taken clause happen together in one cycle
// - only clauses of the current state are evaluated
// - conditions combine terms with NOT, AND, OR and grouping
// - counters and flags compare against a constant with six relations
// - increment adds exactly one to the chosen counter
// - decrement subtracts exactly one from the chosen counter
// - counter reset reloads its configured initial value
// - set drives the chosen flag to one
// - clear drives the chosen flag to zero
// - trigger stops acquisition and ends the run
// - segment end closes the segment and moves to the next one
// - after the last segment the oldest segment is overwritten
// - segmented acquisition runs on until a trigger action
// - segment end is rejected in single-buffer mode
// - start storing raises the buffer write strobe
// - stop storing lowers the buffer write strobe
// - start and stop storing act only in state qualifier mode
// - a post-fill count stores exactly that many more samples
// - without a count the global trigger position count is used
// - a new triggering action cuts a pending segment and marks the rest invalid
// - goto makes the named state the next state
// - up to twenty states
// - twenty counters with width and initial value, twenty flags with initial value
// - an enabled external trigger is evaluated before any state condition
`default_nettype none
package tfs_pkg;
  localparam int NST  = 20;
  localparam int NCL  = 3;
  localparam int NCLT = NST * NCL;
  localparam int NCNT = 20;
  localparam int NFLG = 20;
  localparam int NIN  = 16;
  localparam int CW   = 16;
  localparam int SW   = 5;
  // register byte offsets
  localparam logic [15:0] A_CTRL    = 16'h0000;
  localparam logic [15:0] A_STAT    = 16'h0004;
  localparam logic [15:0] A_DPF     = 16'h0008;
  localparam logic [15:0] A_NSEG    = 16'h000C;
  localparam logic [15:0] A_FLGI    = 16'h0010;
  localparam logic [15:0] A_FLGV    = 16'h0014;
  localparam logic [15:0] A_INV     = 16'h0018;
  localparam logic [15:0] A_CNTI    = 16'h0100;
  localparam logic [15:0] A_CNTV    = 16'h0200;
  localparam logic [15:0] A_CLS     = 16'h0800;
  localparam logic [15:0] A_CLS_END = 16'h0F80;
  // field positions
  localparam int C_ARM = 0;
  localparam int C_QS  = 1;
  localparam int C_EXT = 2;
  localparam int S_RUN = 0;
  localparam int S_DON = 1;
  localparam int S_ERR = 2;
  localparam int S_WE  = 3;
  localparam int S_ST  = 4;
  localparam int S_SEG = 9;
  localparam int I_W   = 16;
  localparam int T_K   = 0;
  localparam int T_OP  = 16;
  localparam int T_IX  = 19;
  localparam int T_SRC = 24;
  localparam int A_LUT = 0;
  localparam int A_COP = 8;
  localparam int A_CIX = 10;
  localparam int A_FOP = 15;
  localparam int A_FIX = 17;
  localparam int A_TOP = 22;
  localparam int A_SOP = 24;
  localparam int A_GEN = 26;
  localparam int A_PEN = 27;
  localparam int X_PF  = 0;
  localparam int X_GT  = 16;
  typedef enum logic [1:0] {SRC_IN = 2'b00, SRC_CNT = 2'b01, SRC_FLG = 2'b10, SRC_ONE = 2'b11} tfs_src_t;
  typedef enum logic [2:0] {CMP_GT = 3'b000, CMP_GE = 3'b001, CMP_EQ = 3'b010,
                            CMP_NE = 3'b011, CMP_LE = 3'b100, CMP_LT = 3'b101} tfs_cmp_t;
  typedef enum logic [1:0] {C_NONE = 2'b00, C_INC = 2'b01, C_DEC = 2'b10, C_RST = 2'b11} tfs_cop_t;
  typedef enum logic [1:0] {F_NONE = 2'b00, F_SET = 2'b01, F_CLR = 2'b10} tfs_fop_t;
  typedef enum logic [1:0] {T_NONE = 2'b00, T_TRIG = 2'b01, T_SEG = 2'b10} tfs_top_t;
  typedef enum logic [1:0] {S_NONE = 2'b00, S_START = 2'b01, S_STOP = 2'b10} tfs_sop_t;
  typedef enum logic [1:0] {PF_IDLE = 2'b00, PF_TRIG = 2'b01, PF_SEG = 2'b10} tfs_pf_t;
  // counter width 0 means full width
  function automatic logic [CW-1:0] cmask(input logic [4:0] w);
    cmask = (w == 5'h00 || w >= 5'(CW)) ? {CW{1'b1}} : CW'((17'h00001 << w) - 17'h00001);
  endfunction
endpackage
`default_nettype wire

// ### hdl/tfs_cond.sv
// tfs_cond: condition of one clause, three terms and a truth table
// assumes term words and resources are stable within the cycle
`timescale 1ns/1ns
`default_nettype none
module tfs_cond
  import tfs_pkg::*;
(
  input  wire logic [31:0]   term [3],
  input  wire logic [7:0]    lut,
  input  wire logic [NIN-1:0] trig_in,
  input  wire logic [CW-1:0] cnt [NCNT],
  input  wire logic [NFLG-1:0] flg,
  output logic               hit
);
  function automatic logic cmp(input logic [2:0] op, input logic [CW-1:0] a, input logic [CW-1:0] k);
    case (op)
      CMP_GT:  cmp = a > k;
      CMP_GE:  cmp = a >= k;
      CMP_EQ:  cmp = a == k;
      CMP_NE:  cmp = a != k;
      CMP_LE:  cmp = a <= k;
      CMP_LT:  cmp = a < k;
      default: cmp = 1'b0;
    endcase
  endfunction
  logic [2:0] t;
  logic [4:0] ix [3];
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ix[i] = term[i][T_IX+:5];
      t[i]  = 1'b0;
      case (term[i][T_SRC+:2])
        SRC_IN:  t[i] = (ix[i] < 5'(NIN)) && trig_in[ix[i][3:0]];
        SRC_CNT: t[i] = (ix[i] < 5'(NCNT)) && cmp(term[i][T_OP+:3], cnt[ix[i]], term[i][T_K+:CW]);
        SRC_FLG: t[i] = (ix[i] < 5'(NFLG)) && cmp(term[i][T_OP+:3], CW'(flg[ix[i]]), term[i][T_K+:CW]);
        default: t[i] = 1'b1;
      endcase
    end
  end
  // any function of three operands, so NOT, AND, OR and grouping all fit
  assign hit = lut[t];
endmodule
`default_nettype wire

// ### hdl/tfs_buf.sv
// tfs_buf: acquisition buffer control, post-fill, segments, write strobe
// assumes take and action fields come from the sequencer in the same cycle
`timescale 1ns/1ns
`default_nettype none
module tfs_buf
  import tfs_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          arm,
  input  wire logic          qual_st,
  input  wire logic [SW-1:0] nseg,
  input  wire logic [CW-1:0] dpf,
  input  wire logic          take,
  input  wire logic [1:0]    top,
  input  wire logic [1:0]    sop,
  input  wire logic          pf_en,
  input  wire logic [CW-1:0] pf,
  output logic               run,
  output logic               wr_en,
  output logic [SW-1:0]      seg,
  output logic               seg_adv,
  output logic               seg_cut,
  output logic [CW-1:0]      inv_cnt,
  output logic               done,
  output logic               seg_err
);
  tfs_pf_t       pend;
  logic [CW-1:0] left;
  logic          store;
  logic [CW-1:0] nval;
  logic          tk_trig, tk_seg, rej, cut, load, fin_t, fin_s;
  assign nval    = pf_en ? pf : dpf;
  // once triggered, a repeated trigger or segment end must not restart or steal the post-fill
  assign tk_trig = take && top == T_TRIG && pend != PF_TRIG;
  assign tk_seg  = take && top == T_SEG && nseg != '0 && pend != PF_TRIG;
  assign rej     = take && top == T_SEG && nseg == '0;
  assign cut     = (tk_trig || tk_seg) && pend == PF_SEG;
  assign load    = tk_trig || tk_seg;
  assign fin_t   = (tk_trig && nval == '0) || (!load && pend == PF_TRIG && wr_en && left == 16'h0001);
  assign fin_s   = (tk_seg && nval == '0) || (!load && pend == PF_SEG && wr_en && left == 16'h0001);
  assign wr_en   = run && (!qual_st || store);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      store <= 1'b0;
    end else if (arm) begin
      store <= 1'b0;
    end else if (take && qual_st) begin
      if (sop == S_START) store <= 1'b1;
      else if (sop == S_STOP) store <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend <= PF_IDLE;
      left <= '0;
    end else if (arm) begin
      pend <= PF_IDLE;
      left <= '0;
    end else if (load) begin
      pend <= (nval == '0) ? PF_IDLE : (tk_trig ? PF_TRIG : PF_SEG);
      left <= nval;
    end else if (pend != PF_IDLE && wr_en) begin
      left <= left - 16'h0001;
      if (left == 16'h0001) pend <= PF_IDLE;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run  <= 1'b0;
      done <= 1'b0;
    end else if (arm) begin
      run  <= 1'b1;
      done <= 1'b0;
    end else if (fin_t) begin
      run  <= 1'b0;
      done <= 1'b1;
    end
  end
  // wrap to segment zero reuses the oldest one
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seg <= '0;
    end else if (arm) begin
      seg <= '0;
    end else if (cut || fin_s) begin
      seg <= (seg >= nseg - 5'h01) ? '0 : seg + 5'h01;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seg_adv <= 1'b0;
      seg_cut <= 1'b0;
      inv_cnt <= '0;
    end else begin
      seg_adv <= cut || fin_s;
      seg_cut <= cut;
      if (arm) inv_cnt <= '0;
      else if (cut) inv_cnt <= left;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) seg_err <= 1'b0;
    else if (rej) seg_err <= 1'b1;
    else if (arm) seg_err <= 1'b0;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_load1;
    tk_trig && !arm && nval == 16'h0001 ##1 wr_en;
  endsequence
  property p_pf_one;
    s_load1 |=> !run && done;
  endproperty
  a_pf_one: assert property (p_pf_one) else $error("post-fill of one did not end the run");
  property p_trig_end;
    tk_trig && !arm && nval == '0 |=> !run && done && !wr_en;
  endproperty
  a_trig_end: assert property (p_trig_end) else $error("trigger did not stop acquisition");
  property p_rej;
    rej && !arm |=> seg_err && $stable(seg);
  endproperty
  a_rej: assert property (p_rej) else $error("segment end accepted in single mode");
  property p_start;
    take && qual_st && sop == S_START && !arm |=> store;
  endproperty
  a_start: assert property (p_start) else $error("start storing ignored");
  property p_noq;
    take && !qual_st && !arm |=> $stable(store);
  endproperty
  a_noq: assert property (p_noq) else $error("store changed outside qualifier mode");
  property p_cut;
    cut && !arm |=> seg_cut && inv_cnt == $past(left);
  endproperty
  a_cut: assert property (p_cut) else $error("segment cut not reported");
endmodule
`default_nettype wire

// ### verif/tfs_sink.sv
// tfs_sink: acquisition buffer side, counts stored samples and segment events
// assumes buffer outputs of the sequencer are synchronous to clk_sys
`timescale 1ns/1ns
`default_nettype none
module tfs_sink (
  input  wire logic       clk_sys,
  input  wire logic       clr,
  input  wire logic       wr_en,
  input  wire logic       seg_adv,
  input  wire logic       seg_cut,
  output logic      [7:0] n_wr,
  output logic      [7:0] n_adv,
  output logic      [7:0] n_cut
);
  // every cycle with the strobe high is one stored sample
  always_ff @(posedge clk_sys) begin
    n_wr  <= clr ? 8'h00 : n_wr + 8'(wr_en);
    n_adv <= clr ? 8'h00 : n_adv + 8'(seg_adv);
    n_cut <= clr ? 8'h00 : n_cut + 8'(seg_cut);
  end
endmodule
`default_nettype wire

// ### verif/tfs_seq_bench.sv
// tfs_seq_bench: register-driven trigger flows run against the sequencer
// assumes the register map and clause layout of tfs_pkg, zero-wait APB
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t %0h %0h", $time, (a), (b)); end end
module tfs_seq_bench
  import tfs_pkg::*;
;
  logic           clk_sys, rst_n, psel, penable, pwrite, ext_trig_in, clr;
  logic           pready, pslverr, wr_en, adv, cut, err;
  logic [15:0]    paddr;
  logic [31:0]    pwdata, prdata, rd;
  logic [NIN-1:0] trig_in;
  logic [7:0]     n_wr, n_adv, n_cut;
  int             n_fail, n_tests;
  int             tk [6] = '{4, 5, 5, 4, 5, 6};
  int             fk [6] = '{5, 6, 4, 5, 4, 5};

  tfs_seq u_tfs_seq (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_in(trig_in), .ext_trig_in(ext_trig_in), .buf_wr_en(wr_en), .buf_seg(),
    .buf_seg_adv(adv), .buf_seg_cut(cut), .buf_inv_cnt(), .buf_done());
  tfs_sink u_tfs_sink (.clk_sys(clk_sys), .clr(clr), .wr_en(wr_en), .seg_adv(adv),
    .seg_cut(cut), .n_wr(n_wr), .n_adv(n_adv), .n_cut(n_cut));

  always #20 clk_sys = ~clk_sys;

  task automatic test_done;
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one edge of idle between transfers keeps psel from being driven twice in a step
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      n_fail++;
      test_done();
    end
  endtask

  task automatic cls(input int c, input logic [31:0] t, input logic [31:0] act, input logic [31:0] x);
    xfer(1'b1, A_CLS + 16'(c * 32), t);
    xfer(1'b1, A_CLS + 16'(c * 32 + 12), act);
    xfer(1'b1, A_CLS + 16'(c * 32 + 16), x);
  endtask

  // ctl of zero polls the current run without arming again
  task automatic run(input logic [31:0] ctl, input logic hit);
    int i;
    if (ctl != 32'h0) begin
      clr <= 1'b1;
      xfer(1'b1, A_CTRL, ctl);
      clr <= 1'b0;
    end
    for (i = 0; i < 30; i++) begin
      xfer(1'b0, A_STAT, 32'h0);
      if (rd[S_DON] === 1'b1 || (!hit && i == 3)) break;
    end
    `CHK(rd[S_DON], hit)
    if (i == 30) test_done();
  endtask

  initial begin
    int k;
    clk_sys = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, ext_trig_in, clr} = 5'h01;
    paddr = 16'h0000;
    pwdata = 32'h0;
    trig_in = '0;
    n_fail = 0;
    n_tests = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    xfer(1'b0, 16'h0040, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    xfer(1'b1, A_CNTI, 32'h7);
    xfer(1'b1, A_FLGI, 32'h2);
    cls(0, 32'h0300_0000, 32'h0500_81AA, 32'h0001_0000);
    cls(3, 32'h0102_0063, 32'h0040_00AA, 32'h0);
    cls(4, 32'h0102_0008, 32'h0843_00AA, 32'h3);
    cls(5, 32'h0300_0000, 32'h0000_02AA, 32'h0);
    run(32'h3, 1'b1);
    xfer(1'b0, A_CNTV, 32'h0);
    `CHK(rd, 32'h8)
    xfer(1'b0, A_FLGV, 32'h0);
    `CHK(rd, 32'h1)
    `CHK(n_wr, 8'h04)
    cls(0, 32'h0300_0000, 32'h0C80_02AA, 32'h0001_0002);
    cls(3, 32'h0300_0000, 32'h0840_00AA, 32'h0);
    cls(4, 32'h0, 32'h0, 32'h0);
    cls(5, 32'h0, 32'h0, 32'h0);
    xfer(1'b1, A_NSEG, 32'h2);
    run(32'h1, 1'b1);
    `CHK(rd & 32'h3E07, 32'h0202)
    `CHK({n_adv, n_cut}, 16'h0101)
    xfer(1'b0, A_CNTV, 32'h0);
    `CHK(rd, 32'h6)
    xfer(1'b0, A_INV, 32'h0);
    `CHK(rd, 32'h2)
    xfer(1'b1, A_NSEG, 32'h0);
    run(32'h1, 1'b1);
    `CHK(rd & 32'h7, 32'h6)
    xfer(1'b1, A_CNTI, 32'h5);
    cls(3, 32'h0, 32'h0, 32'h0);
    for (k = 0; k < 6; k++) begin
      cls(0, 32'h0100_0000 | 32'(k) << 16 | 32'(fk[k]), 32'h0840_00AA, 32'h0);
      run(32'h1, 1'b0);
      cls(0, 32'h0100_0000 | 32'(k) << 16 | 32'(tk[k]), 32'h0840_00AA, 32'h0);
      run(32'h1, 1'b1);
    end
    run(32'h5, 1'b0);
    ext_trig_in <= 1'b1;
    run(32'h0, 1'b1);
    test_done();
  end
endmodule
`default_nettype wire
